// ==== pkg/qa_wd_pkg.sv ====
// shared constants for the question-and-answer watchdog register block
// assumes a byte-wide register port decoded from the serial interface
package qa_wd_pkg;
    // register offsets, byte addresses on the serial register port
    localparam logic [7:0] off_limits_cfg  = 8'haa;
    localparam logic [7:0] off_close_time  = 8'hab;
    localparam logic [7:0] off_open_time   = 8'hac;
    localparam logic [7:0] off_qgen_cfg    = 8'had;
    localparam logic [7:0] off_response    = 8'hae;
    localparam logic [7:0] off_page_select = 8'hf0;
    localparam logic [7:0] off_wd_control  = 8'h9f;
    localparam logic [7:0] off_fault_first = 8'h70;
    // field positions
    localparam int viol_lsb    = 4;
    localparam int mult_lsb    = 0;
    localparam int answer_feedback_select_lsb    = 6;
    localparam int poly_lsb    = 4;
    localparam int seed_lsb    = 0;
    localparam int sw_en_bit   = 6;
    localparam int page_bit    = 0;
    // reset values
    localparam logic [7:0] rst_zero      = 8'h00;
    localparam logic [7:0] rst_limits    = 8'h27;
    localparam logic [7:0] rst_close     = 8'h1d;
    localparam logic [7:0] rst_open      = 8'h1d;
    localparam logic [7:0] rst_control   = 8'h40;
    // timing: one window step is a millisecond
    localparam int clk_hz          = 50_000_000;
    localparam int step_ms         = 1;
    localparam int step_cycles     = clk_hz / 1000 * step_ms;
    // fault flag bits
    localparam int flag_window     = 0;
    localparam int flag_answer     = 1;
    localparam int flag_trip       = 2;
endpackage

// ==== src/qa_wd_sync.sv ====
// three-stage input synchroniser, change counts once stages two and three agree
// assumes an asynchronous pin input and a single system clock
`timescale 1ns/1ns
`default_nettype none
module qa_wd_sync
(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic din,
    output var  logic dout
);
    logic s1_r;   // first stage, read only by s2
    logic s2_r;
    logic s3_r;
    // shift chain
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // filtered level, holds until two later stages agree
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            dout <= 1'b0;
        else if (s2_r == s3_r)
            dout <= s3_r;
    end
endmodule
`default_nettype wire

// ==== src/qa_wd_tick.sv ====
// millisecond step generator for window timing
// assumes the 50 mhz system clock; count shortened by parameter in simulation
`timescale 1ns/1ns
`default_nettype none
module qa_wd_tick
#(
    parameter int step_cycles = qa_wd_pkg::step_cycles
)
(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic run,
    output var  logic tick
);
    localparam int cw = $clog2(step_cycles + 1);
    logic [cw-1:0] cnt_r;   // cycles within the current step
    initial
    begin
        if (step_cycles < 1)
            $error("step_cycles must be at least one");
    end
    // free count, restarted while stopped
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end
        else if (!run)
        begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end
        else if (cnt_r == cw'(step_cycles - 1))
        begin
            cnt_r <= '0;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== src/qa_watchdog_config_regs.sv ====
// question-and-answer watchdog with its configuration registers
// assumes a decoded byte register port from the serial slave, one clock
// Notes on behaviour
// - violation limit in config bits six to four
// - three-bit startup multiplier scales startup window
// - closed window time, whole byte, in steps
// - open window time, whole byte, in steps
// - feedback select bits seven-six, resets zero
// - polynomial select bits five-four, resets zero
// - seed in bits three-zero, resets zero
// - answer register at ae, resets zero
// - page select bit zero, upper bits reserved
// - fault flags clear only on written one
// - flags stay set after fault disappears
// - interrupt output low while any flag set
// - activity input selects active or shutdown
// - watchdog runs when software bit, pin and activity input are all high
`timescale 1ns/1ns
`default_nettype none
module qa_watchdog_config_regs
#(
    parameter int step_cycles   = qa_wd_pkg::step_cycles,
    parameter int startup_steps = 16
)
(
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output var  logic [7:0] reg_rdata,
    input  wire logic       activity_control_in,
    input  wire logic       hardware_wd_enable_pin,
    output var  logic       fault_interrupt_n,
    output var  logic       watchdog_fault_out_n,
    output var  logic       shutdown_state,
    output var  logic       register_page
);
    typedef enum logic [1:0] {st_off, st_startup, st_closed, st_open}
        wd_state_e;
    wd_state_e state_r;                  // window sequencer state
    logic [7:0] limits_r;                // limits config
    logic [7:0] close_r;                 // closed window steps
    logic [7:0] open_r;                  // open window steps
    logic [7:0] qgen_r;                  // question generator config
    logic [7:0] resp_r;                  // host answer
    logic       page_r;                  // page select
    logic [7:0] ctrl_r;                  // watchdog control
    logic [2:0] flags_r;                 // sticky fault flags
    logic [3:0] question_r;              // current question lfsr
    logic [10:0] win_r;                  // step count in window
    logic [3:0] viol_r;                  // violations counted
    logic       trip_r;                  // watchdog output latched
    logic       act_s;                   // synchronised activity input
    logic       wden_s;                  // synchronised enable pin
    logic       tick;                    // one step elapsed
    logic       run;                     // watchdog active
    logic       resp_wr;                 // host answer write
    logic       window_ev;               // answer in closed window or late
    logic       answer_ev;               // wrong answer
    logic [7:0] expect_ans;              // expected answer
    logic [10:0] startup_len;            // startup window in steps
    logic [2:0] flag_clr;                // flag bits written with one
    logic [2:0] flag_set;                // fault events this cycle

    initial
    begin
        if (startup_steps < 1 || startup_steps > 256)
            $error("startup_steps out of range");
    end

    qa_wd_sync u_sync_act
    (
        .clock (clock),
        .arst_n(arst_n),
        .din   (activity_control_in),
        .dout  (act_s)
    );
    qa_wd_sync u_sync_en
    (
        .clock (clock),
        .arst_n(arst_n),
        .din   (hardware_wd_enable_pin),
        .dout  (wden_s)
    );
    qa_wd_tick #(.step_cycles(step_cycles)) u_tick
    (
        .clock (clock),
        .arst_n(arst_n),
        .run   (run),
        .tick  (tick)
    );

    // active only with pin, software bit and activity all high
    assign run = act_s && wden_s && ctrl_r[qa_wd_pkg::sw_en_bit];
    assign shutdown_state = !act_s;
    assign register_page  = page_r;
    assign resp_wr = reg_wr && (reg_addr == qa_wd_pkg::off_response);
    // base unit is a parameter, the real one is not pinned down
    assign startup_len = 11'(qa_wd_pkg::rst_zero) +
        11'(limits_r[qa_wd_pkg::mult_lsb +: 3]) *
        11'(startup_steps);

    // expected answer: question mixed with seed, poly and feedback
    always_comb
    begin
        logic [7:0] q;
        q = {question_r, question_r ^ qgen_r[qa_wd_pkg::seed_lsb +: 4]};
        q = q ^ {2'b00, qgen_r[qa_wd_pkg::poly_lsb +: 2], 4'h0};
        expect_ans = {q[7:6] ^ qgen_r[qa_wd_pkg::answer_feedback_select_lsb +: 2],
                      q[5:0]};
    end

    // an answer in the closed window or a missing one counts as window fault
    assign window_ev = run && ((state_r == st_closed && resp_wr) ||
        (state_r == st_open && tick && win_r >= 11'(open_r)));
    assign answer_ev = run && state_r == st_open && resp_wr &&
        reg_wdata != expect_ans;

    // window sequencer
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= st_off;
            win_r   <= '0;
        end
        else if (!run)
        begin
            state_r <= st_off;
            win_r   <= '0;
        end
        else
        begin
            case (state_r)
                st_off:
                begin
                    state_r <= st_startup;
                    win_r   <= '0;
                end
                st_startup:
                    if (tick && win_r >= startup_len)
                    begin
                        state_r <= st_closed;
                        win_r   <= '0;
                    end
                    else if (tick)
                        win_r <= win_r + 1'b1;
                st_closed:
                    if (resp_wr || (tick && win_r >= 11'(close_r)))
                    begin
                        // a closed-window answer restarts the cycle
                        state_r <= resp_wr ? st_closed : st_open;
                        win_r   <= '0;
                    end
                    else if (tick)
                        win_r <= win_r + 1'b1;
                st_open:
                    if (resp_wr || (tick && win_r >= 11'(open_r)))
                    begin
                        state_r <= st_closed;
                        win_r   <= '0;
                    end
                    else if (tick)
                        win_r <= win_r + 1'b1;
                default:
                    state_r <= st_off;
            endcase
        end
    end

    // question advances after every answered or expired open window
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            question_r <= 4'h0;
        else if (!run)
            question_r <= qgen_r[qa_wd_pkg::seed_lsb +: 4];
        else if (state_r == st_open && (resp_wr || window_ev))
            question_r <= {question_r[2:0],
                           question_r[3] ^ question_r[2] ^ 1'b1};
    end

    // violation counter and watchdog output, latched until disabled
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            viol_r <= '0;
            trip_r <= 1'b0;
        end
        else if (!run)
        begin
            viol_r <= '0;
            trip_r <= 1'b0;
        end
        else if (window_ev || answer_ev)
        begin
            if (viol_r >= {1'b0, limits_r[qa_wd_pkg::viol_lsb +: 3]})
                trip_r <= 1'b1;
            else
                viol_r <= viol_r + 1'b1;
        end
    end
    assign watchdog_fault_out_n = !trip_r;

    // write-one-to-clear mask and this cycle's fault events
    assign flag_clr = (reg_wr && reg_addr == qa_wd_pkg::off_fault_first) ?
        reg_wdata[2:0] : 3'h0;
    assign flag_set[qa_wd_pkg::flag_window] = window_ev;
    assign flag_set[qa_wd_pkg::flag_answer] = answer_ev;
    assign flag_set[qa_wd_pkg::flag_trip]   = trip_r;

    // sticky flags: set wins over a clearing write of one
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            flags_r <= '0;
        else
            flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
    assign fault_interrupt_n = ~|flags_r;

    // configuration register writes
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            limits_r <= qa_wd_pkg::rst_limits;
            close_r  <= qa_wd_pkg::rst_close;
            open_r   <= qa_wd_pkg::rst_open;
            qgen_r   <= qa_wd_pkg::rst_zero;
            resp_r   <= qa_wd_pkg::rst_zero;
            page_r   <= 1'b0;
            ctrl_r   <= qa_wd_pkg::rst_control;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                qa_wd_pkg::off_limits_cfg:  limits_r <= reg_wdata;
                qa_wd_pkg::off_close_time:  close_r  <= reg_wdata;
                qa_wd_pkg::off_open_time:   open_r   <= reg_wdata;
                qa_wd_pkg::off_qgen_cfg:    qgen_r   <= reg_wdata;
                qa_wd_pkg::off_response:    resp_r   <= reg_wdata;
                qa_wd_pkg::off_page_select:
                    page_r <= reg_wdata[qa_wd_pkg::page_bit];
                qa_wd_pkg::off_wd_control:  ctrl_r   <= reg_wdata;
                default:                    ;
            endcase
        end
    end

    // read data registered; unmapped offsets read zero
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                qa_wd_pkg::off_limits_cfg:  reg_rdata <= limits_r;
                qa_wd_pkg::off_close_time:  reg_rdata <= close_r;
                qa_wd_pkg::off_open_time:   reg_rdata <= open_r;
                qa_wd_pkg::off_qgen_cfg:    reg_rdata <= qgen_r;
                qa_wd_pkg::off_response:    reg_rdata <= resp_r;
                qa_wd_pkg::off_page_select: reg_rdata <= {7'h00, page_r};
                qa_wd_pkg::off_wd_control:  reg_rdata <= ctrl_r;
                qa_wd_pkg::off_fault_first: reg_rdata <= {5'h00, flags_r};
                default:                    reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== testbench/qa_wd_checker.sv ====
// port assertions for the watchdog register block
// assumes binding onto qa_watchdog_config_regs, one clock domain
`timescale 1ns/1ns
`default_nettype none
module qa_wd_checker
(
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       activity_control_in,
    input wire logic       hardware_wd_enable_pin,
    input wire logic       fault_interrupt_n,
    input wire logic       watchdog_fault_out_n,
    input wire logic       shutdown_state,
    input wire logic       register_page
);
    // fault flag byte offset
    localparam logic [7:0] flags = qa_wd_pkg::off_fault_first;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // write strobe aimed at the flag byte
    wire flag_wr = reg_wr && reg_addr == flags;
    wire page_wr = reg_wr && reg_addr == qa_wd_pkg::off_page_select;
    wire q_wr = reg_wr && reg_addr == qa_wd_pkg::off_qgen_cfg;
    wire q_rd = reg_rd && reg_addr == qa_wd_pkg::off_qgen_cfg;
    property p_page;
        page_wr |=> register_page == $past(reg_wdata[0]);
    endproperty
    a_page: assert property (p_page) else $error("page bit not taken");
    property p_page_hold;
        !page_wr |=> $stable(register_page);
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("page moved");
    // back-to-back write then read of the question generator config
    property p_qgen;
        q_wr ##1 q_rd |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_qgen: assert property (p_qgen) else $error("qa config lost");
    // sync delay is four cycles, six leaves margin
    property p_shutdown_state;
        $stable(activity_control_in)[*6] |-> shutdown_state == !activity_control_in;
    endproperty
    a_shutdown_state: assert property (p_shutdown_state) else $error("shutdown wrong");
    property p_wd_off;
        !hardware_wd_enable_pin [*8] |-> watchdog_fault_out_n;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("fault out stuck");
    // flags only drop after a write to them, one cycle of slack
    property p_irq_hold;
        !fault_interrupt_n && !flag_wr && !$past(flag_wr) |=> !fault_interrupt_n;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq self-cleared");
    property p_trip_irq;
        $fell(watchdog_fault_out_n) |-> ##[0:2] !fault_interrupt_n;
    endproperty
    a_trip_irq: assert property (p_trip_irq) else $error("trip not flagged");
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    c_trip: cover property (!watchdog_fault_out_n);
    c_flag_wr: cover property (flag_wr);
    c_shutdown_state: cover property ($rose(shutdown_state));
endmodule
bind qa_watchdog_config_regs qa_wd_checker qa_wd_checker_i
(
    .clock(clock), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .activity_control_in(activity_control_in),
    .hardware_wd_enable_pin(hardware_wd_enable_pin),
    .fault_interrupt_n(fault_interrupt_n),
    .watchdog_fault_out_n(watchdog_fault_out_n),
    .shutdown_state(shutdown_state), .register_page(register_page)
);
`default_nettype wire

// ==== testbench/host_model.sv ====
// host controller model: register port strobes and the two control pins
// assumes callers enter its tasks on a falling clock edge
`timescale 1ns/1ns
`default_nettype none
module host_model
(
    input  wire logic       clock,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       activity_control_in,
    output var  logic       hardware_wd_enable_pin
);
    // quiet bus and shutdown request from time zero
    initial
    begin
        {reg_wr, reg_rd, activity_control_in, hardware_wd_enable_pin} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one access held across one rising edge; also writes the answer
    // and the one-to-clear flag bytes
    task automatic bus(input logic w, input logic r, input logic [7:0] a,
                       input logic [7:0] d);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
    endtask
    // released bus shows inverted stale values, never a held copy
    task automatic idle;
        bus(1'b0, 1'b0, ~reg_addr, ~reg_wdata);
    endtask
    // pin levels, no wait
    task automatic pins(input logic act, input logic en);
        activity_control_in = act;
        hardware_wd_enable_pin = en;
    endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the watchdog register block
// assumes host_model drives the ports; reads checked through a queue
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic       clock, arst_n, reg_wr, reg_rd, act, en, rd_d;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic       fault_interrupt_n, watchdog_fault_out_n;
    logic       shutdown_state, register_page;
    logic [7:0] exp_q[$];       // expected read data, oldest first
    int         errors, samples_checked, n;
    localparam logic [7:0] flags = qa_wd_pkg::off_fault_first;
    host_model host_model_i (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .activity_control_in(act), .hardware_wd_enable_pin(en));
    // short step count keeps window timing in the hundreds of cycles
    qa_watchdog_config_regs #(.step_cycles(10), .startup_steps(2))
        qa_watchdog_config_regs_i (.clock(clock), .arst_n(arst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .activity_control_in(act), .hardware_wd_enable_pin(en),
        .fault_interrupt_n(fault_interrupt_n),
        .watchdog_fault_out_n(watchdog_fault_out_n),
        .shutdown_state(shutdown_state), .register_page(register_page));
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host_model_i.bus(1'b1, 1'b0, a, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_model_i.bus(1'b0, 1'b1, a, 8'h00);
    endtask
    // read data lands one edge after the read strobe
    always @(posedge clock) rd_d <= reg_rd & arst_n;
    always @(negedge clock) if (rd_d) chk(reg_rdata, exp_q.pop_front());
    task automatic print_verdict;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // hang guard, roughly twenty-five times the expected run
    initial
    begin
        repeat (8000) @(posedge clock);
        errors++;
        print_verdict();
    end
    initial
    begin
        errors = 0;
        samples_checked = 0;
        rd_d = 1'b0;
        arst_n = 1'b0;
        n = $urandom(41130);
        repeat (4) @(negedge clock);
        arst_n = 1'b1;
        rd(8'haa, 8'h27);
        rd(8'hab, 8'h1d);
        rd(8'hac, 8'h1d);
        rd(8'had, 8'h00);
        rd(8'hae, 8'h00);
        rd(8'hf0, 8'h00);
        rd(8'h55, 8'h00);
        // random bytes, each read back on the very next edge
        for (int i = 0; i < 10; i++)
        begin
            d = 8'($urandom);
            wr(8'haa + 8'(i % 5), d);
            rd(8'haa + 8'(i % 5), d);
        end
        d = 8'($urandom);
        wr(8'hf0, d);
        host_model_i.idle();
        chk({7'h0, register_page}, {7'h0, d[0]});
        // limit zero, no startup delay, long closed window
        wr(8'haa, 8'h00);
        wr(8'hab, 8'h10);
        wr(8'hac, 8'h10);
        host_model_i.idle();
        host_model_i.pins(1'b1, 1'b1);
        repeat (8) @(negedge clock);
        chk({7'h0, shutdown_state}, 8'h00);
        repeat (20) @(negedge clock);
        wr(8'hae, 8'($urandom));
        host_model_i.idle();
        for (n = 0; n < 60 && watchdog_fault_out_n !== 1'b0; n++)
            @(negedge clock);
        chk({7'h0, watchdog_fault_out_n}, 8'h00);
        chk({7'h0, fault_interrupt_n}, 8'h00);
        rd(flags, 8'h05);
        host_model_i.pins(1'b1, 1'b0);
        host_model_i.idle();
        repeat (8) @(negedge clock);
        chk({7'h0, watchdog_fault_out_n}, 8'h01);
        wr(flags, 8'h00);
        rd(flags, 8'h05);
        host_model_i.idle();
        chk({7'h0, fault_interrupt_n}, 8'h00);
        wr(flags, 8'h01);
        rd(flags, 8'h04);
        wr(flags, 8'h04);
        rd(flags, 8'h00);
        host_model_i.idle();
        chk({7'h0, fault_interrupt_n}, 8'h01);
        // software enable off: closed-window write must not trip
        wr(8'h9f, 8'h00);
        host_model_i.idle();
        host_model_i.pins(1'b1, 1'b1);
        repeat (30) @(negedge clock);
        wr(8'hae, 8'h3c);
        host_model_i.idle();
        repeat (40) @(negedge clock);
        chk({7'h0, watchdog_fault_out_n}, 8'h01);
        host_model_i.pins(1'b0, 1'b0);
        repeat (8) @(negedge clock);
        chk({7'h0, shutdown_state}, 8'h01);
        // limit one, multiplier one: a startup answer is ignored, then a
        // right answer, a wrong one, and a closed-window write that trips
        // seed 9, poly 1, feedback 3: first answer 40, second fb
        wr(8'haa, 8'h11);
        wr(8'hab, 8'h02);
        wr(8'hac, 8'h04);
        wr(8'had, 8'hd9);
        wr(8'h9f, 8'h40);
        host_model_i.idle();
        host_model_i.pins(1'b1, 1'b1);
        // startup spans about cycles 4 to 34 after the pins rise
        repeat (25) @(negedge clock);
        wr(8'hae, 8'h00);
        rd(flags, 8'h00);
        // first open window about cycles 64 to 114
        repeat (53) @(negedge clock);
        wr(8'hae, 8'h40);
        rd(flags, 8'h00);
        // second open window about cycles 104 to 154; question moved on
        repeat (38) @(negedge clock);
        wr(8'hae, 8'h40);
        rd(flags, 8'h02);
        chk({7'h0, watchdog_fault_out_n}, 8'h01);
        wr(8'hae, 8'h00);
        host_model_i.idle();
        rd(flags, 8'h07);
        chk({7'h0, watchdog_fault_out_n}, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
